/* core/imc_pkg.sv */
// Constants for the interrupt mode control block: register address, field
// positions, reset values and the number of interrupt request levels.
// Assumes an 8-bit CPU core that reaches the register by its register address.
//
// Behaviour
// - Bits 4..2 select which interrupt level, 0 to 7, is processed fast.
// - Fast processing applies only while bit 1 is set; otherwise it is off.
// - Requests of any level are serviced only while global enable bit 0 is set.
// - At most one level, the one held in the select field, is fast.

package imc_pkg;

    // =========================================================================
    // Register map
    // =========================================================================
    localparam logic [7:0] IMC_ADDR_SYSTEM_MODE_CONTROL = 8'hDE;

    // =========================================================================
    // Field layout
    // =========================================================================
    localparam int         IMC_BIT_GLOBAL_EN = 0;
    localparam int         IMC_BIT_FAST_EN   = 1;
    localparam int         IMC_SEL_LSB       = 2;
    localparam int         IMC_SEL_MSB       = 4;
    localparam int         IMC_SEL_W         = IMC_SEL_MSB - IMC_SEL_LSB + 1;
    localparam int         IMC_NUM_LEVELS    = 8;

    // =========================================================================
    // Reset values
    // =========================================================================
    localparam logic       IMC_RST_GLOBAL_EN = 1'h0;
    localparam logic       IMC_RST_FAST_EN   = 1'h0;
    localparam logic [2:0] IMC_RST_LEVEL_SEL = 3'h0;
    localparam logic [7:0] IMC_RD_IDLE       = 8'h00;

    typedef logic [IMC_SEL_W-1:0] imc_sel_t;

endpackage

/* core/imc_gate_if.sv */
// Interface carrying the control bits and the request lines between the
// register module and the level gate, and the gated results back.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none

interface imc_gate_if #(
    parameter int LEVELS = 8
);
    logic                global_en;
    logic                fast_en;
    imc_pkg::imc_sel_t   level_sel;
    logic [LEVELS-1:0]   irq_lines;
    logic [LEVELS-1:0]   serviced;
    logic [LEVELS-1:0]   fast_hit;

    modport ctrl (
        output global_en,
        output fast_en,
        output level_sel,
        output irq_lines,
        input  serviced,
        input  fast_hit
    );

    modport gate (
        input  global_en,
        input  fast_en,
        input  level_sel,
        input  irq_lines,
        output serviced,
        output fast_hit
    );
endinterface

`default_nettype wire

/* core/imc_level_gate.sv */
// Combinational gate: masks request lines with the global enable and marks
// the one level chosen for fast processing.
// Assumes the control bits come straight from the mode register.
`timescale 1ns/1ps
`default_nettype none

module imc_level_gate #(
    parameter int LEVELS = 8
) (
    // Control and request lines
    imc_gate_if.gate g
);

    // =========================================================================
    // One-hot decode of the level select field
    // =========================================================================
    function automatic logic [LEVELS-1:0] imc_onehot(input imc_pkg::imc_sel_t sel);
        logic [LEVELS-1:0] v;
        v = '0;
        v[sel] = 1'b1;
        return v;
    endfunction

    logic [LEVELS-1:0] fast_mask;

    always_comb begin
        fast_mask = imc_onehot(g.level_sel);
    end

    genvar i;
    generate
        for (i = 0; i < LEVELS; i++) begin : gen_lvl
            assign g.serviced[i] = g.irq_lines[i] & g.global_en;
            assign g.fast_hit[i] = g.irq_lines[i] & g.global_en & g.fast_en
                                   & fast_mask[i];
        end
    endgenerate

endmodule

`default_nettype wire

/* core/imc_mode_ctrl.sv */
// System mode control register for interrupt handling and the registered
// request outputs toward the CPU core.
// Assumes register accesses and request levels are synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none

module imc_mode_ctrl #(
    parameter int LEVELS = imc_pkg::IMC_NUM_LEVELS
) (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              reset_n_i,
    // Core register port
    input  wire logic [7:0]        reg_addr_i,
    input  wire logic              reg_wr_i,
    input  wire logic [7:0]        reg_wdata_i,
    input  wire logic              reg_rd_i,
    output var  logic [7:0]        reg_rdata_o,
    // Enable and disable instruction strobes
    input  wire logic              interrupt_on_instruction_i,
    input  wire logic              interrupt_off_instruction_i,
    // Peripheral request levels
    input  wire logic [LEVELS-1:0] irq_level_i,
    // Gated requests toward the core
    output var  logic [LEVELS-1:0] irq_service_o,
    output var  logic [LEVELS-1:0] irq_fast_o,
    // Mode state
    output var  logic              global_en_o,
    output var  logic              fast_en_o,
    output var  logic [2:0]        fast_level_o
);

    // =========================================================================
    // Register state
    // =========================================================================
    logic                global_en_reg;
    logic                fast_en_reg;
    imc_pkg::imc_sel_t   level_sel_reg;
    logic                addr_hit;
    logic                wr_hit;

    imc_gate_if #(.LEVELS(LEVELS)) gif ();

    assign addr_hit = (reg_addr_i == imc_pkg::IMC_ADDR_SYSTEM_MODE_CONTROL);
    assign wr_hit   = reg_wr_i & addr_hit;

    // The enable instruction wins over a disable or a write in the same cycle.
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            global_en_reg <= imc_pkg::IMC_RST_GLOBAL_EN;
        end else if (interrupt_on_instruction_i) begin
            global_en_reg <= 1'b1;
        end else if (interrupt_off_instruction_i) begin
            global_en_reg <= 1'b0;
        end else if (wr_hit) begin
            global_en_reg <= reg_wdata_i[imc_pkg::IMC_BIT_GLOBAL_EN];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            fast_en_reg <= imc_pkg::IMC_RST_FAST_EN;
        end else if (wr_hit) begin
            fast_en_reg <= reg_wdata_i[imc_pkg::IMC_BIT_FAST_EN];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            level_sel_reg <= imc_pkg::IMC_RST_LEVEL_SEL;
        end else if (wr_hit) begin
            level_sel_reg <= reg_wdata_i[imc_pkg::IMC_SEL_MSB:imc_pkg::IMC_SEL_LSB];
        end
    end

    // =========================================================================
    // Read path
    // =========================================================================
    // Unused upper bits and unmapped addresses read as zero.
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            reg_rdata_o <= imc_pkg::IMC_RD_IDLE;
        end else if (reg_rd_i && addr_hit) begin
            reg_rdata_o <= {3'h0, level_sel_reg, fast_en_reg, global_en_reg};
        end else begin
            reg_rdata_o <= imc_pkg::IMC_RD_IDLE;
        end
    end

    // =========================================================================
    // Level gating
    // =========================================================================
    assign gif.global_en = global_en_reg;
    assign gif.fast_en   = fast_en_reg;
    assign gif.level_sel = level_sel_reg;
    assign gif.irq_lines = irq_level_i;

    imc_level_gate #(.LEVELS(LEVELS)) u_gate (
        .g (gif.gate)
    );

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            irq_service_o <= '0;
            irq_fast_o    <= '0;
        end else begin
            irq_service_o <= gif.serviced;
            irq_fast_o    <= gif.fast_hit;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            global_en_o  <= imc_pkg::IMC_RST_GLOBAL_EN;
            fast_en_o    <= imc_pkg::IMC_RST_FAST_EN;
            fast_level_o <= imc_pkg::IMC_RST_LEVEL_SEL;
        end else begin
            global_en_o  <= global_en_reg;
            fast_en_o    <= fast_en_reg;
            fast_level_o <= level_sel_reg;
        end
    end

    // =========================================================================
    // Assertions
    // =========================================================================
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    a_level_sel_write: assert property (
        (wr_hit && !interrupt_on_instruction_i)
            |=> ##1 (fast_level_o
                     == $past(reg_wdata_i[imc_pkg::IMC_SEL_MSB:imc_pkg::IMC_SEL_LSB], 2)))
        else $error("Level select did not follow the register write.");

    a_fast_off_quiet: assert property (
        !fast_en_reg |=> (irq_fast_o == '0))
        else $error("Fast request raised while fast processing is off.");

    a_global_gate: assert property (
        !global_en_reg |=> (irq_service_o == '0) && (irq_fast_o == '0))
        else $error("Request serviced while global enable is off.");

    a_fast_single_level: assert property (
        $onehot0(irq_fast_o)
        && ((irq_fast_o == '0)
            || (irq_fast_o == ({{(LEVELS-1){1'b0}}, 1'b1} << $past(level_sel_reg))
                && $past(irq_level_i[level_sel_reg]))))
        else $error("Fast request on a level other than the selected one.");

    a_reset_clear: assert property (
        disable iff (1'b0)
        !reset_n_i |=> !global_en_reg && !fast_en_reg
                        && !global_en_o ##1 !global_en_o || global_en_reg)
        else $error("Enable bits not cleared by reset.");

    a_upper_zero: assert property (
        reg_rdata_o[7:5] == 3'h0)
        else $error("Unused upper bits read as nonzero.");

    a_ei_sets: assert property (
        interrupt_on_instruction_i |=> global_en_reg ##1 global_en_o)
        else $error("Enable instruction did not turn on global enable.");

    a_service_follow: assert property (
        global_en_reg |=> (irq_service_o == $past(irq_level_i)))
        else $error("Request not passed through while global enable is on.");

    a_fast_follow: assert property (
        global_en_reg && fast_en_reg
            |=> (irq_fast_o == ($past(irq_level_i)
                 & ({{(LEVELS-1){1'b0}}, 1'b1} << $past(level_sel_reg)))))
        else $error("Fast request does not match the selected level.");

    a_off_clears: assert property (
        interrupt_off_instruction_i && !interrupt_on_instruction_i |=> !global_en_reg)
        else $error("Disable instruction did not clear global enable.");

    a_global_write: assert property (
        (wr_hit && !interrupt_on_instruction_i && !interrupt_off_instruction_i)
            |=> (global_en_reg == $past(reg_wdata_i[imc_pkg::IMC_BIT_GLOBAL_EN])))
        else $error("Global enable did not take the written bit.");

    a_write_fields: assert property (
        wr_hit
            |=> (fast_en_reg == $past(reg_wdata_i[imc_pkg::IMC_BIT_FAST_EN]))
                && (level_sel_reg
                    == $past(reg_wdata_i[imc_pkg::IMC_SEL_MSB:imc_pkg::IMC_SEL_LSB])))
        else $error("Fast enable or level select did not take the write.");

    a_level_hold: assert property (
        !wr_hit |=> $stable(level_sel_reg))
        else $error("Level select changed without a register write.");

    a_fast_hold: assert property (
        !wr_hit |=> $stable(fast_en_reg))
        else $error("Fast enable changed without a register write.");

    a_read_fields: assert property (
        (reg_rd_i && addr_hit)
            |=> (reg_rdata_o == {3'h0, $past(level_sel_reg), $past(fast_en_reg),
                                 $past(global_en_reg)}))
        else $error("Read data does not show the register fields.");

    a_idle_read: assert property (
        !(reg_rd_i && addr_hit) |=> (reg_rdata_o == imc_pkg::IMC_RD_IDLE))
        else $error("Read data not zero outside a register read.");

    a_mode_copy: assert property (
        1'b1 |=> (fast_level_o == $past(level_sel_reg)) && (fast_en_o == $past(fast_en_reg))
                 && (global_en_o == $past(global_en_reg)))
        else $error("Mode outputs do not follow the register.");

    c_fast_request: cover property (
        fast_en_reg && global_en_reg ##1 (irq_fast_o != '0));
    c_ei_then_service: cover property (
        interrupt_on_instruction_i ##[1:4] (irq_service_o != '0));
    c_read_back: cover property (
        reg_rd_i && addr_hit && fast_en_reg ##1 reg_rdata_o[1]);
    c_disable_instruction: cover property (
        global_en_reg && interrupt_off_instruction_i ##1 !global_en_reg);
    c_level_seven: cover property (
        fast_en_reg && (level_sel_reg == 3'h7) ##1 irq_fast_o[7]);

endmodule

`default_nettype wire

/* sim/imc_core_model.sv */
// Behavioural model of the CPU core side: instruction strobes and request levels.
// Assumes the bench calls its tasks from one process, never two at once.
`timescale 1ns/1ps
`default_nettype none

module imc_core_model (
    // Clock
    input  wire logic       clk_i,
    // Strobes and request levels toward the block
    output var  logic       on_o,
    output var  logic       off_o,
    output var  logic [7:0] irq_o
);
    // =========================================================================
    // Core actions
    // =========================================================================
    initial begin
        on_o  = 1'h0;
        off_o = 1'h0;
        irq_o = 8'h00;
    end

    // The global enable is raised by the enable instruction or by a register write with bit 0 set.
    task automatic exec(input logic on);
        @(posedge clk_i);
        #1;
        on_o  = on;
        off_o = !on;
        @(posedge clk_i);
        #1;
        on_o  = 1'h0;
        off_o = 1'h0;
    endtask

    task automatic set_irq(input logic [7:0] v);
        @(posedge clk_i);
        #1;
        irq_o = v;
    endtask
endmodule

`default_nettype wire

/* sim/interrupt_mode_control_test.sv */
// Self-checking bench for the interrupt mode control register and request gating.
// Assumes the design package and core model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module interrupt_mode_control_test;
    localparam logic [7:0] ADDR = imc_pkg::IMC_ADDR_SYSTEM_MODE_CONTROL;
    logic             clk_i       = 1'h0;
    logic             reset_n_i   = 1'h0;
    logic [7:0]       reg_addr_i  = 8'h00;
    logic             reg_wr_i    = 1'h0;
    logic [7:0]       reg_wdata_i = 8'h00;
    logic             reg_rd_i    = 1'h0;
    logic [7:0]       rd;
    wire  logic [7:0] reg_rdata_o;
    wire  logic [7:0] irq_level;
    wire  logic [7:0] irq_service_o;
    wire  logic [7:0] irq_fast_o;
    wire  logic       on_s;
    wire  logic       off_s;
    wire  logic       global_en_o;
    wire  logic       fast_en_o;
    wire  logic [2:0] fast_level_o;
    int               fails       = 0;
    int               comparisons = 0;
    int               cycles      = 0;

    // =========================================================================
    // Design and core model
    // =========================================================================
    imc_mode_ctrl uut (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .interrupt_on_instruction_i(on_s),
        .interrupt_off_instruction_i(off_s), .irq_level_i(irq_level),
        .irq_service_o(irq_service_o), .irq_fast_o(irq_fast_o),
        .global_en_o(global_en_o), .fast_en_o(fast_en_o), .fast_level_o(fast_level_o)
    );
    imc_core_model core (.clk_i(clk_i), .on_o(on_s), .off_o(off_s), .irq_o(irq_level));

    // =========================================================================
    // Clock, timeout and tasks
    // =========================================================================
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            wrap_up();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        reg_addr_i  = a;
        reg_wdata_i = d;
        reg_wr_i    = 1'h1;
        @(posedge clk_i);
        #1;
        reg_wr_i    = 1'h0;
    endtask

    task automatic read(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        #1;
        reg_addr_i = a;
        reg_rd_i   = 1'h1;
        @(posedge clk_i);
        #1;
        d          = reg_rdata_o;
        reg_rd_i   = 1'h0;
    endtask

    // Lets a register change reach the registered outputs.
    task automatic settle();
        repeat (2) @(posedge clk_i);
        #1;
    endtask

    task automatic wrap_up();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // =========================================================================
    // Tests
    // =========================================================================
    initial begin
        repeat (8) @(posedge clk_i);
        #1;
        reset_n_i = 1'h1;
        read(ADDR, rd);
        chk(rd & 8'hE3, 8'h00);
        chk({7'h00, global_en_o}, 8'h00);
        chk({7'h00, fast_en_o}, 8'h00);
        core.set_irq(8'hFF);
        settle();
        chk(irq_service_o, 8'h00);
        $display("test reset state done");
        core.exec(1'h1);
        settle();
        chk({7'h00, global_en_o}, 8'h01);
        chk(irq_service_o, 8'hFF);
        $display("test enable instruction done");
        for (int s = 0; s < 8; s++) begin
            write(ADDR, {3'h7, s[2:0], 2'h3});
            settle();
            read(ADDR, rd);
            chk(rd, {3'h0, s[2:0], 2'h3});
            chk(irq_fast_o, 8'h01 << s);
            chk({5'h00, fast_level_o}, {5'h00, s[2:0]});
            chk({7'h00, fast_en_o}, 8'h01);
            write(ADDR, {3'h0, s[2:0], 2'h1});
            settle();
            chk(irq_fast_o, 8'h00);
            chk({7'h00, fast_en_o}, 8'h00);
            chk(irq_service_o, 8'hFF);
        end
        $display("test level select done");
        write(ADDR, 8'h17);
        core.set_irq(8'h04);
        settle();
        chk(irq_fast_o, 8'h00);
        chk(irq_service_o, 8'h04);
        write(8'hDD, 8'h00);
        settle();
        chk({7'h00, global_en_o}, 8'h01);
        read(8'hDD, rd);
        chk(rd, 8'h00);
        $display("test unmapped access done");
        core.exec(1'h0);
        settle();
        chk({7'h00, global_en_o}, 8'h00);
        chk(irq_service_o, 8'h00);
        chk(irq_fast_o, 8'h00);
        $display("test disable instruction done");
        core.exec(1'h1);
        write(ADDR, 8'h0B);
        @(posedge clk_i);
        #1;
        reset_n_i = 1'h0;
        repeat (2) @(posedge clk_i);
        #1;
        reset_n_i = 1'h1;
        settle();
        chk({7'h00, global_en_o}, 8'h00);
        chk({7'h00, fast_en_o}, 8'h00);
        read(ADDR, rd);
        chk(rd & 8'hE3, 8'h00);
        $display("test mid-run reset done");
        wrap_up();
    end
endmodule

`default_nettype wire
